// *** sbcfg_pkg.sv ***
package sbcfg_pkg;

  // register byte addresses on the configuration bus
  localparam logic [7:0]  SBCFG_CFG_OFS    = 8'h40;
  localparam logic [7:0]  SBCFG_IOBL_OFS   = 8'h1c;

  // reset values
  localparam logic [15:0] SBCFG_CFG_RST    = 16'h0000;
  localparam logic [15:0] SBCFG_IOBL_RST   = 16'h0000;

  // secondary_bus_config field positions
  localparam int          SBCFG_CKDIS_LSB  = 10;
  localparam int          SBCFG_CKDIS_W    = 6;
  localparam int          SBCFG_FINE_BIT   = 9;
  localparam int          SBCFG_BUS_PROTOCOL_SELECT_BIT  = 8;
  localparam int          SBCFG_FREQ_LSB   = 6;
  localparam int          SBCFG_RESTREAM_DISABLE_BIT  = 5;
  localparam int          SBCFG_PPHI_BIT   = 4;
  localparam int          SBCFG_DTD_BIT    = 2;
  localparam int          SBCFG_MDT_LSB    = 0;

  // io_base_limit_reg writable bits: coarse keeps 4 KB steps, fine adds 11:10 and 3:2
  localparam logic [15:0] SBCFG_IOBL_COARSE = 16'hf0f0;
  localparam logic [15:0] SBCFG_IOBL_FINE   = 16'hfcfc;

  // delayed transaction buffer arrangements
  localparam logic [2:0]  SBCFG_BUF_CNT_SMALL  = 3'h4;
  localparam logic [11:0] SBCFG_BUF_SIZE_SMALL = 12'h400;
  localparam logic [2:0]  SBCFG_BUF_CNT_LARGE  = 3'h2;
  localparam logic [11:0] SBCFG_BUF_SIZE_LARGE = 12'h800;

  // register selection codes
  localparam logic [1:0]  SBCFG_SEL_NONE   = 2'h0;
  localparam logic [1:0]  SBCFG_SEL_CFG    = 2'h1;
  localparam logic [1:0]  SBCFG_SEL_IOBL   = 2'h2;

  // axi response codes
  localparam logic [1:0]  SBCFG_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SBCFG_RESP_DECERR = 2'h3;

  // secondary bus frequency codes
  typedef enum logic [1:0] {
    SBCFG_F33  = 2'b00,
    SBCFG_F66  = 2'b01,
    SBCFG_F100 = 2'b10,
    SBCFG_F133 = 2'b11
  } sbcfg_freq_t;

  // delayed transaction limit codes
  typedef enum logic [1:0] {
    SBCFG_MDT_FOUR = 2'b00,
    SBCFG_MDT_ONE  = 2'b01,
    SBCFG_MDT_TWO  = 2'b10,
    SBCFG_MDT_RSVD = 2'b11
  } sbcfg_mdt_t;

endpackage

// *** sbcfg_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - each disable bit tri-states one clock output
// - fine bit enables 1 KB I/O decode
// - protocol bit selects PCI or PCI-X
// - frequency field selects 33/66/100/133 MHz
// - restream disable stops read restreaming in PCI mode only
// - restream disabled in PCI mode: flush prefetch at end
// - prefetch upper bit one disables prefetching
// - depth zero: 4x1KB slow, 2x2KB fast
// - depth one: always four 1 KB buffers
// - limit field caps active and pending transactions
module sbcfg_top
  import sbcfg_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // secondary clock outputs
  input  wire logic              sec_clk_src_i,
  output logic [5:0]             secondary_clock_output_o,
  output logic [5:0]             secondary_clock_output_oe_o,
  // i/o range decode
  input  wire logic [15:0]       io_addr_i,
  output logic                   io_hit_o,
  // secondary bus mode
  output logic                   bus_protocol_select_o,
  output logic [1:0]             bus_frequency_select_o,
  // restream and prefetch
  input  wire logic              secondary_frame_n_i,
  input  wire logic              secondary_stop_n_i,
  output logic                   restream_enable_o,
  output logic                   prefetch_flush_o,
  output logic                   prefetch_mrm_enable_o,
  // delayed transaction resources
  output logic [2:0]             deferred_buffer_count_o,
  output logic [11:0]            deferred_buffer_bytes_o,
  output logic [2:0]             max_deferred_active_o,
  output logic [2:0]             max_deferred_pending_o
);

  // decode shared by the read and write paths
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
    if (addr == ADDR_W'(SBCFG_CFG_OFS))
      return SBCFG_SEL_CFG;
    else if (addr == ADDR_W'(SBCFG_IOBL_OFS))
      return SBCFG_SEL_IOBL;
    else
      return SBCFG_SEL_NONE;
  endfunction

  // reset release through two flops; assertion is still immediate
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // register and bus state
  logic [15:0]       cfg;
  logic [15:0]       iobl;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              bvalid;
  logic [1:0]        bresp;
  logic              rvalid;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              frame_q;
  logic              flush;
  logic              io_hit;
  logic [5:0]        clk_q;

  logic [15:0]       next_cfg;
  logic [15:0]       next_iobl;
  logic              next_aw_held;
  logic              next_w_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              next_flush;
  logic              next_io_hit;

  // decoded fields
  logic        fine;
  logic        pcix;
  logic        rs_dis;
  logic [15:0] iobl_mask;
  logic [15:0] io_base;
  logic [15:0] io_limit;
  logic        do_write;
  logic        ar_iobl;

  assign fine      = cfg[SBCFG_FINE_BIT];
  assign pcix      = cfg[SBCFG_BUS_PROTOCOL_SELECT_BIT];
  assign rs_dis    = cfg[SBCFG_RESTREAM_DISABLE_BIT];
  assign iobl_mask = fine ? SBCFG_IOBL_FINE : SBCFG_IOBL_COARSE;
  // write fires once both halves are held, in whichever order they came
  assign do_write  = aw_held && w_held && !bvalid;
  // read of the base/limit word taken this cycle; kept as a net so checks can look back at it
  assign ar_iobl   = s_axi_arvalid_i && s_axi_arready_o && (reg_sel(s_axi_araddr_i) == SBCFG_SEL_IOBL);

  // handshake outputs; one write and one read in flight at most
  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o  = !w_held && !bvalid;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;

  // write channel capture and register update
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_cfg     = cfg;
    next_iobl    = iobl;
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = SBCFG_RESP_OKAY;
      unique case (reg_sel(aw_addr))
        SBCFG_SEL_CFG:
        begin
          if (w_strb[0])
            next_cfg[7:0] = w_data[7:0];
          if (w_strb[1])
            next_cfg[15:8] = w_data[15:8];
        end
        SBCFG_SEL_IOBL:
        begin
          // extra granularity bits only writable while fine decode is on
          if (w_strb[0])
            next_iobl[7:0] = w_data[7:0] & iobl_mask[7:0];
          if (w_strb[1])
            next_iobl[15:8] = w_data[15:8] & iobl_mask[15:8];
        end
        default:
          next_bresp = SBCFG_RESP_DECERR;
      endcase
    end
    else if (bvalid && s_axi_bready_i)
      next_bvalid = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= SBCFG_RESP_OKAY;
      cfg     <= SBCFG_CFG_RST;
      iobl    <= SBCFG_IOBL_RST;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      cfg     <= next_cfg;
      iobl    <= next_iobl;
    end
  end

  // read channel: answer one cycle after the address is taken
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      next_rvalid = 1'b1;
      next_rresp  = SBCFG_RESP_OKAY;
      unique case (reg_sel(s_axi_araddr_i))
        SBCFG_SEL_CFG:  next_rdata = {16'h0000, cfg};
        SBCFG_SEL_IOBL: next_rdata = {16'h0000, iobl & iobl_mask};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = SBCFG_RESP_DECERR;
        end
      endcase
    end
    else if (rvalid && s_axi_rready_i)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= SBCFG_RESP_OKAY;
    end
    else
    begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  // i/o window; stale fine bits are masked off when fine decode is off
  always_comb
  begin
    io_base     = {iobl[7:4], iobl[3:2] & iobl_mask[3:2], 10'h000};
    io_limit    = {iobl[15:12], fine ? iobl[11:10] : 2'b11, 10'h3ff};
    next_io_hit = (io_addr_i >= io_base) && (io_addr_i <= io_limit);
  end

  // end of transaction: frame released or target stop seen
  always_comb
  begin
    next_flush = rs_dis && !pcix && ((secondary_frame_n_i && !frame_q) || !secondary_stop_n_i);
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_hit  <= 1'b0;
      frame_q <= 1'b1;
      flush   <= 1'b0;
      clk_q   <= 6'h00;
    end
    else
    begin
      io_hit  <= next_io_hit;
      frame_q <= secondary_frame_n_i;
      flush   <= next_flush;
      clk_q   <= {6{sec_clk_src_i}};
    end
  end

  // outputs: registered clock, hit and flush, the rest static decodes of the configuration register
  assign secondary_clock_output_o    = clk_q;
  assign secondary_clock_output_oe_o = ~cfg[SBCFG_CKDIS_LSB +: SBCFG_CKDIS_W];
  assign io_hit_o                    = io_hit;
  // mode pair takes effect on the bus as soon as software writes it
  assign bus_protocol_select_o       = pcix;
  assign bus_frequency_select_o      = cfg[SBCFG_FREQ_LSB +: 2];
  assign restream_enable_o           = !(rs_dis && !pcix);
  assign prefetch_flush_o            = flush;
  assign prefetch_mrm_enable_o       = !cfg[SBCFG_PPHI_BIT];

  // buffer arrangement follows depth bit and bus speed
  always_comb
  begin
    if (!cfg[SBCFG_DTD_BIT] && cfg[SBCFG_FREQ_LSB + 1])
    begin
      deferred_buffer_count_o = SBCFG_BUF_CNT_LARGE;
      deferred_buffer_bytes_o = SBCFG_BUF_SIZE_LARGE;
    end
    else
    begin
      deferred_buffer_count_o = SBCFG_BUF_CNT_SMALL;
      deferred_buffer_bytes_o = SBCFG_BUF_SIZE_SMALL;
    end
  end

  // reserved limit code falls back to the widest setting
  always_comb
  begin
    unique case (sbcfg_mdt_t'(cfg[SBCFG_MDT_LSB +: 2]))
      SBCFG_MDT_ONE: max_deferred_active_o = 3'h1;
      SBCFG_MDT_TWO: max_deferred_active_o = 3'h2;
      default:       max_deferred_active_o = 3'h4;
    endcase
    max_deferred_pending_o = max_deferred_active_o;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  AST_CLK_OE: assert property (do_write && reg_sel(aw_addr) == SBCFG_SEL_CFG && w_strb[1]
    |=> secondary_clock_output_oe_o == ~$past(w_data[15:10])) else $error("clock enable mismatch");
  AST_FINE_HIT: assert property (fine && io_addr_i[15:10] == {iobl[7:4], iobl[3:2]}
    && {iobl[7:4], iobl[3:2]} <= {iobl[15:12], iobl[11:10]} |=> io_hit_o) else $error("fine hit missed");
  AST_COARSE_RD: assert property (rvalid && !fine && $past(ar_iobl) && !$past(fine)
    |-> rdata[3:2] == 2'b00 && rdata[11:10] == 2'b00) else $error("coarse bits visible");
  AST_COARSE_HIT: assert property (!fine && io_addr_i[15:12] == iobl[7:4]
    && iobl[7:4] <= iobl[15:12] |=> io_hit_o) else $error("coarse hit missed");
  AST_MODE: assert property (do_write && reg_sel(aw_addr) == SBCFG_SEL_CFG && w_strb[1]
    |=> bus_protocol_select_o == $past(w_data[8])) else $error("protocol mismatch");
  AST_FREQ: assert property (do_write && reg_sel(aw_addr) == SBCFG_SEL_CFG && w_strb[0]
    |=> bus_frequency_select_o == $past(w_data[7:6])) else $error("frequency mismatch");
  AST_RESTREAM: assert property (pcix |-> restream_enable_o) else $error("restream off in pci-x");
  AST_FLUSH: assert property (rs_dis && !pcix && $rose(secondary_frame_n_i)
    |=> prefetch_flush_o) else $error("flush missing");
  AST_NOFLUSH: assert property (!rs_dis |=> !prefetch_flush_o) else $error("spurious flush");
  AST_PREFETCH: assert property (cfg[SBCFG_PPHI_BIT] |-> !prefetch_mrm_enable_o) else $error("prefetch on");
  AST_DTBUF: assert property (!cfg[SBCFG_DTD_BIT] && bus_frequency_select_o[1]
    |-> deferred_buffer_count_o == 3'h2 && deferred_buffer_bytes_o == 12'h800) else $error("buffer mismatch");
  AST_DTBUF1: assert property (cfg[SBCFG_DTD_BIT] |-> deferred_buffer_count_o == 3'h4) else $error("depth one");
  AST_MDT: assert property (cfg[1:0] == 2'b01 |-> max_deferred_active_o == 3'h1
    && max_deferred_pending_o == 3'h1) else $error("limit mismatch");
  AST_BHOLD: assert property (bvalid && !s_axi_bready_i |=> bvalid) else $error("bvalid dropped");

  COV_CFG_WR: cover property (do_write && reg_sel(aw_addr) == SBCFG_SEL_CFG);
  COV_IOBL_RD: cover property (s_axi_arvalid_i && s_axi_arready_o && reg_sel(s_axi_araddr_i) == SBCFG_SEL_IOBL);
  COV_FLUSH: cover property (prefetch_flush_o);
  COV_FINE_HIT: cover property (fine && io_hit_o);

endmodule

// *** sbcfg_sec_model.sv ***
`timescale 1ns/1ps
// secondary bus agent: free clock source plus one frame or stop event per go pulse
module sbcfg_sec_model (
  // clock and command
  input  wire logic mclk_i,
  input  wire logic go_i,
  input  wire logic kind_i,
  // bus lines; frame and stop idle high as the pull-ups leave them
  output logic      clk_src_o,
  output logic      frame_n_o,
  output logic      stop_n_o
);
  logic [1:0] cnt;

  initial
  begin
    clk_src_o = 1'b0;
    frame_n_o = 1'b1;
    stop_n_o  = 1'b1;
    cnt       = 2'h0;
  end

  // frame held low three cycles then released; stop low alone for one cycle
  always @(posedge mclk_i)
  begin
    clk_src_o <= ~clk_src_o;
    cnt       <= (cnt != 2'h0) ? cnt - 2'h1 : 2'h0;
    if (go_i && !kind_i)
    begin
      frame_n_o <= 1'b0;
      cnt       <= 2'h3;
    end
    if (cnt == 2'h1)
      frame_n_o <= 1'b1;
    stop_n_o <= !(go_i && kind_i);
  end
endmodule

// *** bridge_secondary_bus_config_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module bridge_secondary_bus_config_bench;
  import sbcfg_pkg::*;
  // bench drive
  logic        mclk_i = 0, rst_n_i = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, go = 0, kind = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rs = 32'h25453b41;
  logic [15:0] io_addr = 0, d;
  // design answers
  logic        awready, wready, bvalid, rvalid, arready, sck_src, frame_n, stop_n;
  logic        io_hit, proto, restream, flush, mrm;
  logic [1:0]  bresp, rresp, freq;
  logic [31:0] rdata;
  logic [5:0]  sck, oe;
  logic [2:0]  cnt, act, pend, mf;
  logic [11:0] bytes;
  logic [33:0] exp_q[$], exp_v, got_v;
  logic [2:0]  mf_tab [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
  logic [15:0] rcfg [3] = '{16'h0020, 16'h0120, 16'h0000};
  logic [3:0]  fl, strb = 4'h3;
  int          n_fail = 0, checks_done = 0;

  always #50 mclk_i = ~mclk_i;

  sbcfg_top uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sec_clk_src_i(sck_src),
    .secondary_clock_output_o(sck), .secondary_clock_output_oe_o(oe), .io_addr_i(io_addr), .io_hit_o(io_hit),
    .bus_protocol_select_o(proto), .bus_frequency_select_o(freq), .secondary_frame_n_i(frame_n),
    .secondary_stop_n_i(stop_n), .restream_enable_o(restream), .prefetch_flush_o(flush),
    .prefetch_mrm_enable_o(mrm), .deferred_buffer_count_o(cnt), .deferred_buffer_bytes_o(bytes),
    .max_deferred_active_o(act), .max_deferred_pending_o(pend));

  sbcfg_sec_model partner (.mclk_i(mclk_i), .go_i(go), .kind_i(kind), .clk_src_o(sck_src),
    .frame_n_o(frame_n), .stop_n_o(stop_n));

  // scoreboard: sampled half a cycle before the handshake edge, so no race with it
  always @(negedge mclk_i)
    if ((bvalid && bready) || (rvalid && rready))
    begin
      exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
      got_v = (bvalid && bready) ? {bresp, 32'h0} : {rresp, rdata};
      `CHK(got_v, exp_v)
    end

  // xorshift step for the random register values
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tmo();
    n_fail++;
    $display("[FAIL] %0t handshake wait ran out got %h exp %h", $time, 1'b0, 1'b1);
    end_sim();
  endtask

  // one write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
    int   k;
    logic ha, hw, la, lw, hb;
    exp_q.push_back({er, 32'h0});
    @(posedge mclk_i);
    awaddr  <= a;
    wdata   <= {16'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    ha = 0;
    hw = 0;
    k  = 0;
    while (!(ha && hw) && k < 40)
    begin
      @(negedge mclk_i);
      la = awvalid && awready;
      lw = wvalid && wready;
      @(posedge mclk_i);
      k++;
      if (la)
      begin
        ha = 1;
        awvalid <= 1'b0;
      end
      if (lw)
      begin
        hw = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do
    begin
      @(negedge mclk_i);
      hb = bvalid;
      @(posedge mclk_i);
      k++;
    end while (!hb && k < 80);
    bready <= 1'b0;
    if (!(ha && hw && hb))
      tmo();
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
    int   k;
    logic h;
    exp_q.push_back({er, 16'h0, v});
    @(posedge mclk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    k = 0;
    do
    begin
      @(negedge mclk_i);
      h = arready;
      @(posedge mclk_i);
      k++;
    end while (!h && k < 40);
    arvalid <= 1'b0;
    do
    begin
      @(negedge mclk_i);
      h = rvalid;
      @(posedge mclk_i);
      k++;
    end while (!h && k < 80);
    rready <= 1'b0;
    if (!h)
      tmo();
  endtask

  // all decoded outputs worked out from the register value
  task automatic chk_dec(input logic [15:0] v);
    logic [2:0] lim;
    lim = (v[1:0] == 2'h1) ? 3'h1 : (v[1:0] == 2'h2) ? 3'h2 : 3'h4;
    @(negedge mclk_i);
    `CHK(oe, ~v[15:10])
    `CHK(sck, {6{~sck_src}})
    `CHK(proto, v[8])
    `CHK(freq, v[7:6])
    `CHK(restream, !(v[5] && !v[8]))
    `CHK(mrm, !v[4])
    `CHK({cnt, bytes}, (v[7] && !v[2]) ? {3'h2, 12'h800} : {3'h4, 12'h400})
    `CHK({act, pend}, {lim, lim})
  endtask

  // one frame end or stop from the partner, flush pulses counted
  task automatic burst(input logic kk, input int e);
    @(posedge mclk_i);
    go   <= 1'b1;
    kind <= kk;
    @(posedge mclk_i);
    go <= 1'b0;
    fl = 0;
    repeat (8) @(negedge mclk_i) fl += flush;
    `CHK(fl, e)
  endtask

  task automatic ioc(input logic [15:0] a, input logic e);
    @(posedge mclk_i);
    io_addr <= a;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    `CHK(io_hit, e)
  endtask

  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(SBCFG_CFG_OFS, 16'h0000, SBCFG_RESP_OKAY);
    chk_dec(16'h0000);
    $display("test reset values done");
    // valid mode and frequency pairs only, every limit and policy code, both depths
    for (int i = 0; i < 10; i++)
    begin
      mf = mf_tab[i % 5];
      d  = {6'h1 << (i % 6), 1'b0, mf, 1'b0, 2'(i >> 1), 1'(i / 5), 2'(i)};
      wr(SBCFG_CFG_OFS, d, SBCFG_RESP_OKAY); // mode and frequency go out in one word
      rd(SBCFG_CFG_OFS, d, SBCFG_RESP_OKAY);
      chk_dec(d);
    end
    $display("test decode table done");
    for (int i = 0; i < 6; i++)
    begin
      rs = xs(rs);
      d  = rs[15:0];
      d[7] = d[7] && d[8];
      d[6] = d[6] || (d[8] && !d[7]);
      d[2] = 1'b0;
      d[9] = 1'b0;
      wr(SBCFG_CFG_OFS, d, SBCFG_RESP_OKAY);
      rd(SBCFG_CFG_OFS, d, SBCFG_RESP_OKAY);
      chk_dec(d);
    end
    $display("test random values done");
    // restream off flushes only in conventional mode
    for (int j = 0; j < 3; j++)
    begin
      wr(SBCFG_CFG_OFS, rcfg[j], SBCFG_RESP_OKAY);
      burst(1'b0, (j == 0) ? 1 : 0);
      burst(1'b1, (j == 0) ? 1 : 0);
    end
    $display("test restream done");
    wr(SBCFG_CFG_OFS, 16'h0000, SBCFG_RESP_OKAY);
    wr(SBCFG_IOBL_OFS, 16'hffff, SBCFG_RESP_OKAY);
    rd(SBCFG_IOBL_OFS, 16'hf0f0, SBCFG_RESP_OKAY);
    wr(SBCFG_IOBL_OFS, 16'h1010, SBCFG_RESP_OKAY);
    ioc(16'h1c00, 1'b1);
    ioc(16'h2000, 1'b0);
    ioc(16'h0fff, 1'b0);
    wr(SBCFG_CFG_OFS, 16'h0200, SBCFG_RESP_OKAY);
    wr(SBCFG_IOBL_OFS, 16'h1414, SBCFG_RESP_OKAY);
    rd(SBCFG_IOBL_OFS, 16'h1414, SBCFG_RESP_OKAY);
    ioc(16'h1000, 1'b0);
    ioc(16'h1400, 1'b1);
    ioc(16'h17ff, 1'b1);
    ioc(16'h1800, 1'b0);
    wr(SBCFG_CFG_OFS, 16'h0000, SBCFG_RESP_OKAY);
    rd(SBCFG_IOBL_OFS, 16'h1010, SBCFG_RESP_OKAY);
    ioc(16'h1000, 1'b1);
    $display("test io granularity done");
    // unmapped word is refused and leaves the register alone
    wr(8'h44, 16'h1234, SBCFG_RESP_DECERR);
    rd(8'h44, 16'h0000, SBCFG_RESP_DECERR);
    rd(SBCFG_CFG_OFS, 16'h0000, SBCFG_RESP_OKAY);
    $display("test unmapped done");
    // low lane only: the upper byte of the register must keep its old value
    strb <= 4'h1;
    wr(SBCFG_CFG_OFS, 16'hfc55, SBCFG_RESP_OKAY);
    strb <= 4'h3;
    rd(SBCFG_CFG_OFS, 16'h0055, SBCFG_RESP_OKAY);
    chk_dec(16'h0055);
    $display("test byte lanes done");
    end_sim();
  end
endmodule
